// ### hdl/dcf_top.sv
// Dual-clock 64 x 36 queue with read-port bus matching, mailboxes and parity
`timescale 1ns/1ps
module dcf_top
    import dcf_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic write_port_clock_in,
    input wire logic read_port_clock_in,
    input wire dcf_aport_s aport_ctl_in,
    input wire dcf_bport_s bport_ctl_in,
    input wire logic [35:0] write_port_data_in,
    output logic [35:0] write_port_data_out,
    output logic write_port_data_oe_out,
    input wire logic [35:0] read_port_data_in,
    output logic [35:0] read_port_data_out,
    output logic read_port_data_oe_out,
    input wire logic odd_parity_in,
    input wire logic offset_select_hi_in,
    input wire logic offset_select_lo_in,
    output logic queue_full_n_out,
    output logic queue_nearly_full_n_out,
    output logic queue_empty_n_out,
    output logic queue_nearly_empty_n_out,
    output logic a_to_b_mail_flag_n_out,
    output logic b_to_a_mail_flag_n_out,
    output logic write_port_parity_err_n_out,
    output logic read_port_parity_err_n_out
);
    // ****************************************
    // Pin sampling
    // ****************************************
    logic a_clk_q;
    logic b_clk_q;
    dcf_aport_s a_ctl;
    dcf_bport_s b_ctl;
    logic [35:0] a_din;
    logic [35:0] b_din;
    logic odd_q;
    logic [1:0] fs_q;

    dcf_pin_sync #(.W(42)) u_sync_a (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .pin_in({write_port_clock_in, aport_ctl_in, write_port_data_in}),
        .level_out({a_clk_q, a_ctl, a_din})
    );

    dcf_pin_sync #(.W(46)) u_sync_b (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .pin_in({read_port_clock_in, bport_ctl_in, read_port_data_in}),
        .level_out({b_clk_q, b_ctl, b_din})
    );

    dcf_pin_sync #(.W(3)) u_sync_misc (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .pin_in({odd_parity_in, offset_select_hi_in, offset_select_lo_in}),
        .level_out({odd_q, fs_q})
    );

    // ****************************************
    // Port clock edges and qualified accesses
    // ****************************************
    logic a_clk_d_r;
    logic b_clk_d_r;
    logic a_rise;
    logic b_rise;
    logic a_act;
    logic b_act;
    logic b_mail;
    logic fifo_wr;
    logic fifo_rd;
    logic pop;
    logic mb1_wr;
    logic mb1_rd;
    logic mb2_wr;
    logic mb2_rd;
    logic full_n_r;
    logic empty_n_r;
    logic mb1_flag_n_r;
    logic mb2_flag_n_r;
    logic [1:0] lane_r;

    // Each port clock is edge-detected on its own, so their phase relation does not matter
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            a_clk_d_r <= 1'b0;
            b_clk_d_r <= 1'b0;
        end else begin
            a_clk_d_r <= a_clk_q;
            b_clk_d_r <= b_clk_q;
        end
    end

    assign a_rise = a_clk_q & ~a_clk_d_r;
    assign b_rise = b_clk_q & ~b_clk_d_r;
    assign a_act = a_rise & ~a_ctl.sel_n & a_ctl.en;
    assign b_act = b_rise & ~b_ctl.sel_n & b_ctl.en;
    assign b_mail = b_ctl.size == SIZE_MAIL;

    assign fifo_wr = a_act & a_ctl.wr & ~a_ctl.mbox & full_n_r;
    assign mb1_wr = a_act & a_ctl.wr & a_ctl.mbox & mb1_flag_n_r;
    assign mb2_rd = a_act & ~a_ctl.wr & a_ctl.mbox;
    // Read port writes with a queue size have nowhere to go and are dropped
    assign fifo_rd = b_act & ~b_ctl.wr & ~b_mail & empty_n_r;
    assign mb1_rd = b_act & ~b_ctl.wr & b_mail;
    assign mb2_wr = b_act & b_ctl.wr & b_mail & mb2_flag_n_r;
    assign pop = fifo_rd & (lane_r >= dcf_last_lane(b_ctl.size));

    // ****************************************
    // Offset strap
    // ****************************************
    logic [1:0] strap_cnt_r;
    logic strap_ready_r;
    logic strap_done_r;
    logic [6:0] offset_r;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strap_cnt_r <= 2'h0;
            strap_ready_r <= 1'b0;
            strap_done_r <= 1'b0;
            offset_r <= OFFSET_0;
        end else if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            strap_ready_r <= strap_cnt_r == STRAP_WAIT;
            if (strap_ready_r) begin
                strap_done_r <= 1'b1;
                unique case (fs_q)
                    2'h0: offset_r <= OFFSET_0;
                    2'h1: offset_r <= OFFSET_1;
                    2'h2: offset_r <= OFFSET_2;
                    2'h3: offset_r <= OFFSET_3;
                endcase
            end
        end
    end

    // ****************************************
    // Queue storage and pointers
    // ****************************************
    logic [35:0] mem [FIFO_DEPTH_C];
    logic [6:0] wptr_r;
    logic [6:0] rptr_r;
    logic [6:0] wptr_nxt;
    logic [6:0] rptr_nxt;

    assign wptr_nxt = wptr_r + {6'h0, fifo_wr};
    assign rptr_nxt = rptr_r + {6'h0, pop};

    always_ff @(posedge clk_sys_in) begin
        if (fifo_wr) begin
            mem[wptr_r[ADDR_W-1:0]] <= a_din;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wptr_r <= 7'h0;
            rptr_r <= 7'h0;
        end else begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
        end
    end

    // ****************************************
    // Flags: opposite pointer passes two stages of the flag's own port clock
    // ****************************************
    logic [6:0] rptr_a_r;
    logic [6:0] wptr_b_r;
    logic a_live_r;
    logic af_n_r;
    logic ae_n_r;
    logic [6:0] used_a;
    logic [6:0] used_b;

    assign used_a = wptr_nxt - rptr_a_r;
    assign used_b = wptr_b_r - rptr_nxt;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rptr_a_r <= 7'h0;
            a_live_r <= 1'b0;
            full_n_r <= 1'b0;
            af_n_r <= 1'b0;
        end else if (a_rise) begin
            rptr_a_r <= rptr_r;
            a_live_r <= 1'b1;
            full_n_r <= a_live_r & (used_a != FIFO_DEPTH_C);
            af_n_r <= a_live_r & ((FIFO_DEPTH_C - used_a) > offset_r);
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wptr_b_r <= 7'h0;
            empty_n_r <= 1'b0;
            ae_n_r <= 1'b0;
        end else if (b_rise) begin
            wptr_b_r <= wptr_r;
            empty_n_r <= used_b != 7'h0;
            ae_n_r <= used_b > offset_r;
        end
    end

    // ****************************************
    // Mailboxes
    // ****************************************
    logic [35:0] mail_ab_r;
    logic [35:0] mail_ba_r;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mail_ab_r <= 36'h0;
            mail_ba_r <= 36'h0;
        end else begin
            if (mb1_wr) begin
                mail_ab_r <= a_din;
            end
            if (mb2_wr) begin
                mail_ba_r <= b_din;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mb1_flag_n_r <= 1'b1;
            mb2_flag_n_r <= 1'b1;
        end else begin
            // Clocks may coincide; the new write wins over a read in the same cycle
            if (mb1_wr) begin
                mb1_flag_n_r <= 1'b0;
            end else if (mb1_rd) begin
                mb1_flag_n_r <= 1'b1;
            end
            if (mb2_wr) begin
                mb2_flag_n_r <= 1'b0;
            end else if (mb2_rd) begin
                mb2_flag_n_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // Read port sizing and output data
    // ****************************************
    logic [35:0] b_bus;
    logic [35:0] b_dout_r;
    logic [35:0] a_dout_r;

    dcf_bus_match u_bus_match (
        .word_in(mem[rptr_r[ADDR_W-1:0]]),
        .size_in(b_ctl.size),
        .endian_lane_select_in(b_ctl.endian),
        .swap_in(b_ctl.swap),
        .lane_in(lane_r),
        .pgen_in(b_ctl.pgen),
        .odd_in(odd_q),
        .bus_out(b_bus)
    );

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lane_r <= 2'h0;
        end else if (fifo_rd) begin
            lane_r <= pop ? 2'h0 : lane_r + 2'h1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            b_dout_r <= 36'h0;
        end else if (fifo_rd) begin
            b_dout_r <= b_bus;
        end else if (mb1_rd) begin
            b_dout_r <= b_ctl.pgen ? dcf_gen_parity(mail_ab_r, odd_q) : mail_ab_r;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            a_dout_r <= 36'h0;
        end else begin
            a_dout_r <= a_ctl.pgen ? dcf_gen_parity(mail_ba_r, odd_q) : mail_ba_r;
        end
    end

    // ****************************************
    // Passive parity check
    // ****************************************
    logic pe_a_n_r;
    logic pe_b_n_r;
    logic a_force;
    logic b_force;

    // Generation shares the check trees, so a set-up generating mailbox read reports no error
    assign a_force = ~a_ctl.sel_n & a_ctl.en & ~a_ctl.wr & a_ctl.mbox & a_ctl.pgen;
    assign b_force = ~b_ctl.sel_n & b_ctl.en & ~b_ctl.wr & b_mail & b_ctl.pgen;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pe_a_n_r <= 1'b1;
            pe_b_n_r <= 1'b1;
        end else begin
            pe_a_n_r <= a_force | ~|dcf_parity_err(a_din, odd_q);
            pe_b_n_r <= b_force
                | ~|(dcf_parity_err(b_din, odd_q)
                & dcf_valid_bytes(b_ctl.size, b_ctl.endian));
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign write_port_data_out = a_dout_r;
    assign write_port_data_oe_out = ~a_ctl.sel_n & ~a_ctl.wr;
    assign read_port_data_out = b_dout_r;
    assign read_port_data_oe_out = ~b_ctl.sel_n & ~b_ctl.wr;
    assign queue_full_n_out = full_n_r;
    assign queue_nearly_full_n_out = af_n_r;
    assign queue_empty_n_out = empty_n_r;
    assign queue_nearly_empty_n_out = ae_n_r;
    assign a_to_b_mail_flag_n_out = mb1_flag_n_r;
    assign b_to_a_mail_flag_n_out = mb2_flag_n_r;
    assign write_port_parity_err_n_out = pe_a_n_r;
    assign read_port_parity_err_n_out = pe_b_n_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_byte_first;
        fifo_rd && b_ctl.size == SIZE_BYTE && lane_r == 2'h0;
    endsequence

    sequence s_last_lane;
        fifo_rd && lane_r >= dcf_last_lane(b_ctl.size);
    endsequence

    sequence s_mail_posted;
        mb1_wr ##1 !mb1_rd;
    endsequence

    a_depth_bound: assert property ((wptr_r - rptr_r) <= FIFO_DEPTH_C)
        else $error("Queue holds more than its depth");
    a_pop_nonempty: assert property (pop |-> wptr_r != rptr_r)
        else $error("Queue popped while empty");
    a_full_on_edge: assert property ($changed(full_n_r) |-> $past(a_rise))
        else $error("Full flag moved off a write clock edge");
    a_empty_on_edge: assert property ($changed(empty_n_r) |-> $past(b_rise))
        else $error("Empty flag moved off a read clock edge");
    a_nearly_empty: assert property (ae_n_r |-> empty_n_r)
        else $error("Nearly-empty high while queue empty");
    a_nearly_full: assert property (!full_n_r |-> !af_n_r)
        else $error("Nearly-full high while queue full");
    a_byte_holds: assert property (s_byte_first |=> rptr_r == $past(rptr_r))
        else $error("Byte read popped on first lane");
    a_lane_pops: assert property (s_last_lane |=> rptr_r == $past(rptr_r) + 7'h1)
        else $error("Last lane did not pop the queue");
    a_mail_holds: assert property (s_mail_posted |=> !mb1_flag_n_r)
        else $error("Mailbox flag released without a read");
    a_mail_release: assert property (mb1_rd && !mb1_wr |=> mb1_flag_n_r)
        else $error("Mailbox flag not released by read");
    a_port_a_hiz: assert property (a_ctl.sel_n |-> !write_port_data_oe_out)
        else $error("Write port driven while deselected");
    a_parity_force: assert property (b_force |=> read_port_parity_err_n_out)
        else $error("Parity error during generating mailbox read");
endmodule

// ### hdl/dcf_pkg.sv
// Constants, carriers and helper functions for the dual-clock FIFO with mailboxes
package dcf_pkg;

    localparam int DATA_W = 36;
    localparam int ADDR_W = 6;
    localparam logic [6:0] FIFO_DEPTH_C = 7'h40;

    // Read port bus size codes
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_BYTE = 2'h2;
    localparam logic [1:0] SIZE_MAIL = 2'h3;

    // Byte-order swap modes
    localparam logic [1:0] SWAP_NONE = 2'h0;
    localparam logic [1:0] SWAP_FULL = 2'h1;
    localparam logic [1:0] SWAP_HALF = 2'h2;
    localparam logic [1:0] SWAP_INNER = 2'h3;

    // Preset nearly-full and nearly-empty offsets, chosen by the two offset selects
    localparam logic [6:0] OFFSET_0 = 7'h10;
    localparam logic [6:0] OFFSET_1 = 7'h0C;
    localparam logic [6:0] OFFSET_2 = 7'h08;
    localparam logic [6:0] OFFSET_3 = 7'h04;

    // Cycles after reset release before strap pins have passed the pin synchroniser
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef struct packed {
        logic sel_n;
        logic en;
        logic wr;
        logic mbox;
        logic pgen;
    } dcf_aport_s;

    typedef struct packed {
        logic sel_n;
        logic en;
        logic wr;
        logic [1:0] size;
        logic endian;
        logic [1:0] swap;
        logic pgen;
    } dcf_bport_s;

    // Parity bit sits in the top bit of each 9-bit byte
    function automatic logic [35:0] dcf_gen_parity(input logic [35:0] d, input logic odd);
        logic [35:0] r;
        r = d;
        for (int i = 0; i < 4; i++) begin
            r[9*i+8] = (^d[9*i +: 8]) ^ odd;
        end
        return r;
    endfunction

    function automatic logic [3:0] dcf_parity_err(input logic [35:0] d, input logic odd);
        logic [3:0] e;
        e = 4'h0;
        for (int i = 0; i < 4; i++) begin
            e[i] = (^d[9*i +: 9]) != odd;
        end
        return e;
    endfunction

    function automatic logic [35:0] dcf_swap(input logic [35:0] d, input logic [1:0] mode);
        logic [35:0] r;
        unique case (mode)
            SWAP_NONE: r = d;
            SWAP_FULL: r = {d[8:0], d[17:9], d[26:18], d[35:27]};
            SWAP_HALF: r = {d[17:0], d[35:18]};
            SWAP_INNER: r = {d[26:18], d[35:27], d[8:0], d[17:9]};
        endcase
        return r;
    endfunction

    function automatic logic [1:0] dcf_last_lane(input logic [1:0] size);
        logic [1:0] r;
        unique case (size)
            SIZE_WORD: r = 2'h1;
            SIZE_BYTE: r = 2'h3;
            SIZE_LONG,
            SIZE_MAIL: r = 2'h0;
        endcase
        return r;
    endfunction

    // Bytes on the read bus that carry data for the chosen size and endian
    function automatic logic [3:0] dcf_valid_bytes(input logic [1:0] size, input logic endian);
        logic [3:0] r;
        unique case (size)
            SIZE_WORD: r = endian ? 4'h3 : 4'hC;
            SIZE_BYTE: r = endian ? 4'h1 : 4'h8;
            SIZE_LONG,
            SIZE_MAIL: r = 4'hF;
        endcase
        return r;
    endfunction

endpackage

// ### hdl/dcf_pin_sync.sv
// Three-stage pin synchroniser; a bit changes once stages two and three agree
`timescale 1ns/1ps
module dcf_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] agree;

    assign agree = ~(s2_r ^ s3_r);

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_out <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_out <= (agree & s3_r) | (~agree & level_out);
        end
    end
endmodule

// ### hdl/dcf_bus_match.sv
// Read port byte swapping, bus sizing and parity generation for queue words
`timescale 1ns/1ps
module dcf_bus_match
    import dcf_pkg::*;
(
    input wire logic [35:0] word_in,
    input wire logic [1:0] size_in,
    input wire logic endian_lane_select_in,
    input wire logic [1:0] swap_in,
    input wire logic [1:0] lane_in,
    input wire logic pgen_in,
    input wire logic odd_in,
    output logic [35:0] bus_out
);
    logic [35:0] sw;
    logic [35:0] placed;

    assign sw = dcf_swap(word_in, swap_in);

    always_comb begin
        placed = 36'h0;
        unique case (size_in)
            SIZE_WORD: begin
                // Big end first on upper lanes, little end first on lower lanes
                if (!endian_lane_select_in) begin
                    placed[35:18] = lane_in[0] ? sw[17:0] : sw[35:18];
                end else begin
                    placed[17:0] = lane_in[0] ? sw[35:18] : sw[17:0];
                end
            end
            SIZE_BYTE: begin
                if (!endian_lane_select_in) begin
                    placed[35:27] = sw[9*(3-lane_in) +: 9];
                end else begin
                    placed[8:0] = sw[9*lane_in +: 9];
                end
            end
            SIZE_LONG,
            SIZE_MAIL: placed = sw;
        endcase
        bus_out = pgen_in ? dcf_gen_parity(placed, odd_in) : placed;
    end
endmodule

// ### dv/dcf_port_host.sv
// Far-side port controller clocks for both queue ports
`timescale 1ns/1ps
module dcf_port_host (
    input wire logic clk_sys_in,
    output logic write_port_clock_out,
    output logic read_port_clock_out
);
    // ********
    // Free-running port clocks
    // ********
    // Unequal rates so the port edges keep drifting against each other
    logic [2:0] a_cnt_r = 3'h0;
    logic [2:0] b_cnt_r = 3'h0;
    initial begin
        write_port_clock_out = 1'b0;
        read_port_clock_out = 1'b0;
    end
    always @(posedge clk_sys_in) begin
        a_cnt_r <= (a_cnt_r == 3'h4) ? 3'h0 : a_cnt_r + 3'h1;
        b_cnt_r <= (b_cnt_r == 3'h5) ? 3'h0 : b_cnt_r + 3'h1;
        if (a_cnt_r == 3'h4) begin
            write_port_clock_out <= ~write_port_clock_out;
        end
        if (b_cnt_r == 3'h5) begin
            read_port_clock_out <= ~read_port_clock_out;
        end
    end
endmodule

// ### dv/dcf_top_tb_top.sv
// Self-checking bench for the dual-clock queue with mailboxes
`timescale 1ns/1ps
module dcf_top_tb_top;
    import dcf_pkg::*;
    logic clk, rst_n, aclk, bclk, odd, woe;
    logic full_n, afull_n, empty_n, aempty_n, mab_n, mba_n, aperr_n, boe, bperr_n;
    dcf_aport_s actl;
    dcf_bport_s bctl;
    logic [35:0] adat, bdat, wdo, rdo;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    // Strap is tied to code 1 below
    localparam int FS_OFF = OFFSET_1;
    dcf_port_host u_host (.clk_sys_in(clk), .write_port_clock_out(aclk),
        .read_port_clock_out(bclk));
    dcf_top u_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .write_port_clock_in(aclk),
        .read_port_clock_in(bclk), .aport_ctl_in(actl), .bport_ctl_in(bctl),
        .write_port_data_in(adat), .write_port_data_out(wdo),
        .write_port_data_oe_out(woe), .read_port_data_in(bdat),
        .read_port_data_out(rdo), .read_port_data_oe_out(boe), .odd_parity_in(odd),
        .offset_select_hi_in(1'b0), .offset_select_lo_in(1'b1),
        .queue_full_n_out(full_n), .queue_nearly_full_n_out(afull_n),
        .queue_empty_n_out(empty_n), .queue_nearly_empty_n_out(aempty_n),
        .a_to_b_mail_flag_n_out(mab_n), .b_to_a_mail_flag_n_out(mba_n),
        .write_port_parity_err_n_out(aperr_n), .read_port_parity_err_n_out(bperr_n));
    // ********
    // Shared tasks
    // ********
    task automatic results();
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Controls are set one cycle after a port clock fall; enable clears one cycle after the next fall
    task automatic a_op(input logic w, input logic m, input logic p, input logic [35:0] d);
        @(negedge aclk);
        @(posedge clk);
        actl <= '{1'b0, 1'b1, w, m, p};
        adat <= d;
        @(negedge aclk);
        @(posedge clk);
        actl.en <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic b_op(input logic w, input logic [1:0] sz, input logic e,
        input logic [1:0] sw, input logic p, input logic [35:0] d);
        @(negedge bclk);
        @(posedge clk);
        bctl <= '{1'b0, 1'b1, w, sz, e, sw, p};
        bdat <= d;
        @(negedge bclk);
        @(posedge clk);
        bctl.en <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic wait_b();
        repeat (3) @(posedge bclk);
        repeat (6) @(posedge clk);
    endtask
    function automatic logic [35:0] swp(input logic [35:0] d, input int m);
        case (m)
            1: return {d[8:0], d[17:9], d[26:18], d[35:27]};
            2: return {d[17:0], d[35:18]};
            3: return {d[26:18], d[35:27], d[8:0], d[17:9]};
            default: return d;
        endcase
    endfunction
    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        @(posedge clk);
        chk(full_n, 1'b0);
        chk(mab_n & mba_n, 1'b1);
        wait_b();
        chk(full_n, 1'b1);
        chk(afull_n, 1'b1);
        chk(empty_n | aempty_n, 1'b0);
    endtask
    task automatic t_mail();
        a_op(1'b1, 1'b1, 1'b0, 36'h1_2345_6789);
        chk(mab_n, 1'b0);
        a_op(1'b1, 1'b1, 1'b0, 36'hF_0000_000F);
        b_op(1'b0, SIZE_MAIL, 1'b0, SWAP_NONE, 1'b0, 36'h0);
        chk(rdo, 36'h1_2345_6789);
        chk(mab_n, 1'b1);
        b_op(1'b1, SIZE_MAIL, 1'b0, SWAP_NONE, 1'b0, 36'h9_8765_4321);
        chk(mba_n, 1'b0);
        a_op(1'b0, 1'b1, 1'b0, 36'h0);
        chk(woe, 1'b1);
        chk(wdo, 36'h9_8765_4321);
        chk(mba_n, 1'b1);
        actl.sel_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(woe, 1'b0);
    endtask
    // Both lane sizes across all swap modes, endian order flipping with each swap mode
    task automatic t_size();
        logic [35:0] s;
        logic e;
        int w;
        for (int z = 1; z < 3; z++) begin
            for (int sw = 0; sw < 4; sw++) begin
                w = (z == 1) ? 18 : 9;
                e = sw[0] ^ z[1];
                s = swp(36'h1_2345_6789, sw);
                a_op(1'b1, 1'b0, 1'b0, 36'h1_2345_6789);
                wait_b();
                for (int k = 0; k < 36 / w; k++) begin
                    b_op(1'b0, 2'(z), e, 2'(sw), 1'b0, 36'h0);
                    s = swp(36'h1_2345_6789, sw) >> (w * (e ? k : 36 / w - 1 - k));
                    s = s & ((36'h1 << w) - 36'h1);
                    chk(rdo, e ? s : s << (36 - w));
                end
            end
        end
    endtask
    task automatic t_fill();
        for (int i = 0; i < 64; i++) begin
            a_op(1'b1, 1'b0, 1'b0, 36'hA_5000_0000 + 36'(i));
            wait_b();
            if (i == 0) chk(empty_n, 1'b1);
            if (i == FS_OFF - 1 || i == FS_OFF) chk(aempty_n, i == FS_OFF);
            if (i == 62 - FS_OFF || i == 63 - FS_OFF) chk(afull_n, i == 62 - FS_OFF);
        end
        chk(full_n, 1'b0);
        a_op(1'b1, 1'b0, 1'b0, 36'hF_FFFF_FFFF);
        for (int i = 0; i < 64; i++) begin
            b_op(1'b0, SIZE_LONG, 1'b0, SWAP_NONE, 1'b0, 36'h0);
            chk(rdo, 36'hA_5000_0000 + 36'(i));
        end
        wait_b();
        chk(empty_n, 1'b0);
        b_op(1'b0, SIZE_LONG, 1'b0, SWAP_NONE, 1'b0, 36'h0);
        chk(rdo, 36'hA_5000_003F);
    endtask
    task automatic t_parity();
        a_op(1'b1, 1'b0, 1'b0, 36'h0);
        chk(aperr_n, 1'b0);
        a_op(1'b1, 1'b0, 1'b0, 36'h0);
        wait_b();
        b_op(1'b0, SIZE_LONG, 1'b0, SWAP_NONE, 1'b0, 36'h0);
        chk(rdo, 36'h0);
        chk(boe, 1'b1);
        chk(bperr_n, 1'b0);
        b_op(1'b0, SIZE_LONG, 1'b0, SWAP_NONE, 1'b1, 36'h0);
        chk(rdo, 36'h8_0402_0100);
        // Queue-sized write on the read port is dropped but still parity checked
        b_op(1'b1, SIZE_LONG, 1'b0, SWAP_NONE, 1'b0, 36'h8_0402_0100);
        chk(bperr_n, 1'b1);
        a_op(1'b1, 1'b0, 1'b0, 36'h8_0402_0100);
        chk(aperr_n, 1'b1);
    endtask
    // ********
    // Clock, reset, sequence and hang guard
    // ********
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        rst_n = 1'b0;
        odd = 1'b1;
        actl = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        bctl = '{1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0};
        adat = 36'h0;
        bdat = 36'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_mail();
        t_size();
        t_fill();
        t_parity();
        results();
    end
endmodule
